/* File: core/rfe_access.sv */
// Purpose: Decode remote register accesses into flash, EEPROM and control targets
// Assumes: One request outstanding; memory controllers answer with done pulses
// Notes:   Staging buffer words are read out by the flash controller during programming
`default_nettype none
module rfe_access
  import rfe_pkg::*;
#(
  parameter int BUF_WORDS = RFE_BLOCK_BYTES / 4
)(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         req_valid,
  input  wire rfe_req_t     req,
  output logic              req_ready,
  output logic              rsp_valid,
  output logic [31:0]       rsp_data,
  output logic              rsp_err,
  output logic              ctrl_valid,
  output rfe_req_t          ctrl_req,
  input  wire logic         ctrl_done,
  input  wire logic [31:0]  ctrl_rdata,
  output logic              ee_valid,
  output rfe_mem_req_t      ee_req,
  input  wire logic         ee_done,
  input  wire logic [31:0]  ee_rdata,
  output logic              fl_valid,
  output rfe_mem_req_t      fl_req,
  input  wire logic         fl_done,
  input  wire logic [31:0]  fl_rdata,
  input  wire logic [13:0]  buf_rd_idx,
  output logic [31:0]       buf_rd_data
);
  if (BUF_WORDS != RFE_BLOCK_BYTES / 4)
  begin : g_bad_buf_words
    $error("BUF_WORDS must match 64 kB block");
  end

  typedef enum {S_IDLE, S_CTRL, S_EE, S_FL_RD, S_ERASE, S_PROG, S_RESP} rfe_state_t;
  rfe_state_t  state_q;
  rfe_tgt_t    tgt;
  logic [31:0] rdata_q;
  logic        err_q;
  logic [23:0] prog_addr_q;
  logic [31:0] buf_mem [BUF_WORDS];

  // Address decode ahead of any memory transaction
  function automatic rfe_tgt_t decode(input logic [31:0] a);
    rfe_tgt_t t;
    logic [31:0] off;
    off = a - RFE_FL_BASE;
    t = RFE_T_NONE;
    if (a >= RFE_FL_BASE) // RQ2
    begin
      if (off == RFE_WADDR_LO || off == RFE_WADDR_HI) t = RFE_T_WADDR;
      else if (off >= RFE_WBUF_LO && off <= RFE_WBUF_HI) t = RFE_T_WBUF;
      else if (a <= RFE_FL_PHYS_LAST) t = RFE_T_FL_RD;
      else t = RFE_T_FL_RSV;
    end
    else if (a >= RFE_EE_BASE && a <= RFE_EE_LAST) t = RFE_T_EE; // RQ9
    else if (a >= RFE_VENDOR_BASE) t = RFE_T_CTRL; // RQ1
    return t;
  endfunction

  wire rfe_tgt_t    req_tgt   = decode(req.addr); // RQ11
  wire logic [31:0] fl_off    = req.addr - RFE_FL_BASE; // RQ3
  wire logic [31:0] ee_off    = req.addr - RFE_EE_BASE; // RQ10
  wire logic [13:0] wbuf_idx  = 14'((fl_off - RFE_WBUF_LO) >> 2);
  wire logic        take      = req_valid && req_ready;
  wire logic        on_sector = (req.wdata[23:0] & RFE_SECTOR_MASK) == 24'h00_0000; // RQ8
  wire logic        buf_wr    = take && req.wr && req_tgt == RFE_T_WBUF;
  wire logic        buf_rd    = take && !req.wr && req_tgt == RFE_T_WBUF;

  assign req_ready   = (state_q == S_IDLE);
  assign rsp_valid   = (state_q == S_RESP);
  assign rsp_data    = rdata_q;
  assign rsp_err     = err_q;
  assign buf_rd_data = buf_mem[buf_rd_idx];

  // Staging buffer; flash never written directly
  always_ff @(posedge clk)
  begin
    if (buf_wr) // RQ4
      buf_mem[wbuf_idx] <= req.wdata;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q     <= S_IDLE;
      rdata_q     <= 32'h0000_0000;
      err_q       <= 1'b0;
      prog_addr_q <= 24'h00_0000;
      ctrl_valid  <= 1'b0;
      ee_valid    <= 1'b0;
      fl_valid    <= 1'b0;
      ctrl_req    <= '0;
      ee_req      <= '0;
      fl_req      <= '0;
    end
    else
    begin
      ctrl_valid <= 1'b0;
      ee_valid   <= 1'b0;
      fl_valid   <= 1'b0;
      case (state_q)
        S_IDLE:
          if (take)
          begin
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            state_q <= S_RESP;
            case (req_tgt)
              RFE_T_CTRL:
              begin
                ctrl_valid <= 1'b1;
                ctrl_req   <= req;
                state_q    <= S_CTRL;
              end
              RFE_T_EE:
              begin
                ee_valid <= 1'b1; // RQ10
                ee_req   <= '{op: req.wr ? RFE_OP_WRITE : RFE_OP_READ, addr: 24'(ee_off), wdata: req.wdata};
                state_q  <= S_EE;
              end
              RFE_T_FL_RD:
                if (!req.wr)
                begin
                  fl_valid <= 1'b1; // RQ3
                  fl_req   <= '{op: RFE_OP_READ, addr: fl_off[23:0], wdata: 32'h0000_0000};
                  state_q  <= S_FL_RD;
                end
                else
                  err_q <= 1'b1;
              RFE_T_WBUF:
                if (buf_rd)
                  rdata_q <= buf_mem[wbuf_idx];
              RFE_T_WADDR:
                if (req.wr)
                begin
                  // Commit: host has filled and padded the buffer
                  prog_addr_q <= req.wdata[23:0]; // RQ7
                  fl_valid    <= 1'b1;
                  if (on_sector) // RQ8
                  begin
                    fl_req  <= '{op: RFE_OP_ERASE, addr: req.wdata[23:0], wdata: 32'h0000_0000};
                    state_q <= S_ERASE;
                  end
                  else
                  begin
                    fl_req  <= '{op: RFE_OP_PROG, addr: req.wdata[23:0], wdata: 32'h0000_0000};
                    state_q <= S_PROG;
                  end
                end
                else
                  rdata_q <= {8'h00, prog_addr_q};
              default:
                err_q <= 1'b1;
            endcase
          end
        S_CTRL:
          if (ctrl_done)
          begin
            // Writes answer zero, whatever the target leaves on its bus
            if (!ctrl_req.wr)
              rdata_q <= ctrl_rdata;
            state_q <= S_RESP;
          end
        S_EE:
          if (ee_done)
          begin
            if (ee_req.op == RFE_OP_READ)
              rdata_q <= ee_rdata;
            state_q <= S_RESP;
          end
        S_FL_RD:
          if (fl_done)
          begin
            rdata_q <= fl_rdata;
            state_q <= S_RESP;
          end
        S_ERASE:
          if (fl_done)
          begin
            fl_valid <= 1'b1; // RQ8
            fl_req   <= '{op: RFE_OP_PROG, addr: prog_addr_q, wdata: 32'h0000_0000};
            state_q  <= S_PROG;
          end
        S_PROG:
          if (fl_done)
            state_q <= S_RESP;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  property p_erase_then_prog;
    @(posedge clk) disable iff (sys_rst)
      (state_q == S_ERASE && fl_done) |=> (fl_valid && fl_req.op == RFE_OP_PROG);
  endproperty
  a_erase_then_prog: assert property (p_erase_then_prog) else $error("No program after erase"); // RQ8

  property p_boundary_erase;
    @(posedge clk) disable iff (sys_rst)
      (take && req.wr && req_tgt == RFE_T_WADDR) |=>
        (fl_valid && (fl_req.op == RFE_OP_ERASE) == (fl_req.addr[17:0] == 18'h0_0000));
  endproperty
  a_boundary_erase: assert property (p_boundary_erase) else $error("Erase choice wrong"); // RQ8

  property p_fl_addr;
    @(posedge clk) disable iff (sys_rst)
      (take && !req.wr && req_tgt == RFE_T_FL_RD) |=>
        (fl_valid && fl_req.op == RFE_OP_READ && fl_req.addr == $past(req.addr[23:0]));
  endproperty
  a_fl_addr: assert property (p_fl_addr) else $error("Flash read address wrong"); // RQ3

  property p_ee_addr;
    @(posedge clk) disable iff (sys_rst)
      (take && req_tgt == RFE_T_EE) |=>
        (ee_valid && ee_req.addr == 24'($past(req.addr) - 32'hFBFF_0000));
  endproperty
  a_ee_addr: assert property (p_ee_addr) else $error("EEPROM address wrong"); // RQ10

  property p_ee_window;
    @(posedge clk) disable iff (sys_rst)
      ee_valid |-> ee_req.addr < 24'h00_2000;
  endproperty
  a_ee_window: assert property (p_ee_window) else $error("EEPROM outside window"); // RQ9

  property p_no_fl_write;
    @(posedge clk) disable iff (sys_rst)
      fl_valid |-> fl_req.op != RFE_OP_WRITE;
  endproperty
  a_no_fl_write: assert property (p_no_fl_write) else $error("Direct flash write"); // RQ4

  property p_low_unmapped;
    @(posedge clk) disable iff (sys_rst)
      (take && req.addr < 32'h0000_A000) |=> (rsp_valid && rsp_err && !ctrl_valid);
  endproperty
  a_low_unmapped: assert property (p_low_unmapped) else $error("Low address not refused"); // RQ1

  property p_flash_region;
    @(posedge clk) disable iff (sys_rst)
      (take && req.addr >= 32'hFE00_0000) |=> (!ee_valid && !ctrl_valid);
  endproperty
  a_flash_region: assert property (p_flash_region) else $error("Flash region misrouted"); // RQ2

  property p_buf_read;
    @(posedge clk) disable iff (sys_rst)
      buf_rd |=> (rsp_valid && rsp_data == buf_mem[$past(wbuf_idx)]);
  endproperty
  a_buf_read: assert property (p_buf_read) else $error("Buffer readback wrong"); // RQ11

  property p_wbuf_local;
    @(posedge clk) disable iff (sys_rst)
      buf_wr |=> (rsp_valid && !rsp_err && !fl_valid);
  endproperty
  a_wbuf_local: assert property (p_wbuf_local) else $error("Buffer write reached flash"); // RQ4

  sequence s_commit_on_sector;
    take && req.wr && req_tgt == RFE_T_WADDR && req.wdata[17:0] == 18'h0_0000;
  endsequence

  sequence s_erase_issued;
    fl_valid && fl_req.op == RFE_OP_ERASE && fl_req.addr == $past(req.wdata[23:0]);
  endsequence

  property p_commit_erase;
    @(posedge clk) disable iff (sys_rst)
      s_commit_on_sector |=> s_erase_issued;
  endproperty
  a_commit_erase: assert property (p_commit_erase) else $error("Sector erase not issued"); // RQ8
endmodule
`default_nettype wire

/* File: core/rfe_pkg.sv */
// Purpose: Constants and carrier types for the remote flash/EEPROM register access engine
// Assumes: Single clock, 32-bit register words, byte-addressed memories
// Notes:   Region bounds are compared on the full register address
// Overview of operation
// [RQ1] From 0x0000A000 upward is vendor space
// [RQ2] Top 32 MB is flash; 16 MB physical
// [RQ3] Flash read address is reg minus 0xFE000000
// [RQ4] No direct flash writes; 64 kB staging buffer
// [RQ5] Host fills whole buffer before commit
// [RQ6] Host pads unused buffer bytes with 0xFF
// [RQ7] Write-address register write commits programming
// [RQ8] Erase sector on boundary, then program block
// [RQ9] EEPROM window 0xFBFF0000 to 0xFBFF1FFF
// [RQ10] EEPROM address is reg minus 0xFBFF0000
// [RQ11] Decode target from address before memory access
`default_nettype none
package rfe_pkg;
  localparam logic [31:0] RFE_VENDOR_BASE  = 32'h0000_A000;
  localparam logic [31:0] RFE_EE_BASE      = 32'hFBFF_0000;
  localparam logic [31:0] RFE_EE_LAST      = 32'hFBFF_1FFF;
  localparam logic [31:0] RFE_FL_BASE      = 32'hFE00_0000;
  localparam logic [31:0] RFE_FL_PHYS_LAST = 32'hFEFF_FFFF;
  localparam logic [31:0] RFE_WADDR_LO     = 32'h0000_0000;
  localparam logic [31:0] RFE_WBUF_LO      = 32'h0000_0004;
  localparam logic [31:0] RFE_WBUF_HI      = 32'h0001_0003;
  localparam logic [31:0] RFE_WADDR_HI     = 32'h0001_0004;
  localparam int          RFE_BLOCK_BYTES  = 32'h0001_0000;
  localparam logic [23:0] RFE_SECTOR_MASK  = 24'h03_FFFF;
  localparam logic [7:0]  RFE_PAD_BYTE     = 8'hFF;

  typedef enum logic [2:0] {RFE_T_NONE, RFE_T_CTRL, RFE_T_EE, RFE_T_FL_RD,
                            RFE_T_WBUF, RFE_T_WADDR, RFE_T_FL_RSV} rfe_tgt_t;
  typedef enum logic [1:0] {RFE_OP_READ, RFE_OP_WRITE, RFE_OP_ERASE, RFE_OP_PROG} rfe_op_t;

  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rfe_req_t;

  typedef struct packed {
    rfe_op_t     op;
    logic [23:0] addr;
    logic [31:0] wdata;
  } rfe_mem_req_t;
endpackage
`default_nettype wire

/* File: test/rfe_mem_model.sv */
// Purpose: Stand-in for the flash, EEPROM and control targets
// Assumes: One op outstanding; done follows valid after 0 to 3 idle cycles
// Notes:   Read word carries the byte address; an idle read bus shows the inverse
`default_nettype none
module rfe_mem_model
  import rfe_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         fl_valid,
  input  wire rfe_mem_req_t fl_req,
  output logic              fl_done,
  output logic [31:0]       fl_rdata,
  input  wire logic         ee_valid,
  input  wire rfe_mem_req_t ee_req,
  output logic              ee_done,
  output logic [31:0]       ee_rdata,
  input  wire logic         ctrl_valid,
  input  wire rfe_req_t     ctrl_req,
  output logic              ctrl_done,
  output logic [31:0]       ctrl_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  rfe_mem_req_t log_q[$];
  logic [31:0]  c_addr;
  initial {fl_done, ee_done, ctrl_done, fl_rdata, ee_rdata, ctrl_rdata} = '0;
  always @(posedge clk)
    if (fl_valid === 1'b1)
    begin
      log_q.push_back(fl_req);
      repeat ($urandom_range(3)) @(posedge clk);
      #1 {fl_done, fl_rdata} = {1'b1, 8'hA5, log_q[$].addr};
      @(posedge clk);
      #1 {fl_done, fl_rdata} = {1'b0, ~fl_rdata};
    end
  always @(posedge clk)
    if (ee_valid === 1'b1)
    begin
      log_q.push_back(ee_req);
      repeat ($urandom_range(3)) @(posedge clk);
      #1 {ee_done, ee_rdata} = {1'b1, 8'h5E, log_q[$].addr};
      @(posedge clk);
      #1 {ee_done, ee_rdata} = {1'b0, ~ee_rdata};
    end
  always @(posedge clk)
    if (ctrl_valid === 1'b1)
    begin
      c_addr = ctrl_req.addr;
      repeat ($urandom_range(3)) @(posedge clk);
      #1 {ctrl_done, ctrl_rdata} = {1'b1, c_addr};
      @(posedge clk);
      #1 {ctrl_done, ctrl_rdata} = {1'b0, ~c_addr};
    end
endmodule
`default_nettype wire

/* File: test/tb_remote_flash_eeprom_access.sv */
// Purpose: Self-checking bench for the register access engine
// Assumes: Host keeps one request outstanding
// Notes:   Expected answers queued by the driver, popped by the monitor
`default_nettype none
module tb_remote_flash_eeprom_access;
  timeunit 1ns;
  timeprecision 1ns;
  import rfe_pkg::*;
  logic clk, sys_rst, req_valid, req_ready, rsp_valid, rsp_err;
  logic ctrl_valid, ctrl_done, ee_valid, ee_done, fl_valid, fl_done;
  logic [31:0] rsp_data, ctrl_rdata, ee_rdata, fl_rdata, buf_rd_data, a, d0;
  logic [13:0] buf_rd_idx;
  rfe_req_t req, ctrl_req;
  rfe_mem_req_t ee_req, fl_req, m;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int errors, check_count;
  rfe_access uut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
    .ctrl_valid(ctrl_valid), .ctrl_req(ctrl_req), .ctrl_done(ctrl_done), .ctrl_rdata(ctrl_rdata),
    .ee_valid(ee_valid), .ee_req(ee_req), .ee_done(ee_done), .ee_rdata(ee_rdata),
    .fl_valid(fl_valid), .fl_req(fl_req), .fl_done(fl_done), .fl_rdata(fl_rdata),
    .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data));
  rfe_mem_model mdl (.clk(clk), .fl_valid(fl_valid), .fl_req(fl_req), .fl_done(fl_done),
    .fl_rdata(fl_rdata), .ee_valid(ee_valid), .ee_req(ee_req), .ee_done(ee_done),
    .ee_rdata(ee_rdata), .ctrl_valid(ctrl_valid), .ctrl_req(ctrl_req),
    .ctrl_done(ctrl_done), .ctrl_rdata(ctrl_rdata));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic access(input logic wr, input logic [31:0] ad, input logic [31:0] dt,
                        input logic [31:0] ed, input logic ee);
    int n;
    exp_q.push_back({ee, ed});
    req_valid = 1'b1;
    req = '{wr: wr, addr: ad, wdata: dt};
    for (n = 0; req_ready !== 1'b1 && n < 64; n++) @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 1'b0;
    req = ~req;
    for (n = 0; rsp_valid !== 1'b1 && n < 64; n++) @(posedge clk) #1;
    if (n == 64)
      errors++;
  endtask
  task automatic op_chk(input rfe_op_t op, input logic [23:0] ad, input logic [31:0] dt, input logic cw);
    m = (mdl.log_q.size() > 0) ? mdl.log_q.pop_front() : '1;
    check("mem_op", {6'h0, m.op, m.addr}, {6'h0, op, ad});
    if (cw)
      check("mem_wdata", m.wdata, dt);
  endtask
  task automatic final_report;
    $display("Counts: %0d checks, %0d errors", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
    if (rsp_valid === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      check("rsp_data", rsp_data, e[31:0]);
      check("rsp_err", {31'h0, rsp_err}, {31'h0, e[32]});
    end
  initial
  begin
    // About 33k cycles expected; margin for model latency
    #(60_000 * 100);
    errors++;
    final_report();
  end
  initial
  begin
    {errors, check_count} = '0;
    {sys_rst, req_valid, req, buf_rd_idx} = {1'b1, 1'b0, 65'h0, 14'h0};
    void'($urandom(32'h9092));
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    access(0, 32'h0000_A004, 0, 32'h0000_A004, 0);
    access(0, 32'hFBFF_2000, 0, 32'hFBFF_2000, 0);
    access(0, 32'h0000_9FFC, 0, 0, 1);
    d0 = $urandom;
    access(1, 32'h0000_A008, d0, 0, 0);
    check("ctrl_wdata", ctrl_req.wdata, d0);
    $display("Test control region done");
    for (int i = 0; i < 2; i++)
    begin
      a = i ? 32'h1FFC : 32'h0;
      d0 = $urandom;
      access(1, RFE_EE_BASE + a, d0, 0, 0);
      op_chk(RFE_OP_WRITE, a[23:0], d0, 1);
      access(0, RFE_EE_BASE + a, 0, {8'h5E, a[23:0]}, 0);
      op_chk(RFE_OP_READ, a[23:0], 0, 0);
    end
    $display("Test eeprom window done");
    for (int i = 0; i < 4; i++)
    begin
      // Random reads kept clear of the staging window at the bottom
      a = (i == 0) ? RFE_FL_PHYS_LAST - 3 : RFE_FL_BASE + 32'h0002_0000 + ($urandom & 32'h00FD_FFFC);
      access(0, a, 0, {8'hA5, a[23:0]}, 0);
      op_chk(RFE_OP_READ, a[23:0], 0, 0);
    end
    access(0, 32'hFF00_0000, 0, 0, 1);
    access(1, 32'hFE02_0000, $urandom, 0, 1);
    $display("Test flash read and refusals done");
    d0 = $urandom;
    for (int k = 0; k < RFE_BLOCK_BYTES / 4; k++)
      access(1, RFE_FL_BASE + RFE_WBUF_LO + 4 * k, (k == 0) ? d0 : {4{RFE_PAD_BYTE}}, 0, 0);
    check("buf_first", buf_rd_data, d0);
    buf_rd_idx = 14'h3FFF;
    @(posedge clk) #1;
    check("buf_last", buf_rd_data, 32'hFFFF_FFFF);
    access(0, RFE_FL_BASE + RFE_WBUF_LO, 0, d0, 0);
    access(1, RFE_FL_BASE + RFE_WADDR_LO, 32'h0004_0000, 0, 0);
    op_chk(RFE_OP_ERASE, 24'h04_0000, 0, 0);
    op_chk(RFE_OP_PROG, 24'h04_0000, 0, 0);
    access(1, RFE_FL_BASE + RFE_WADDR_HI, 32'h0005_0000, 0, 0);
    op_chk(RFE_OP_PROG, 24'h05_0000, 0, 0);
    check("extra_ops", mdl.log_q.size(), 0);
    access(0, RFE_FL_BASE + RFE_WADDR_LO, 0, 32'h0005_0000, 0);
    repeat (2) @(posedge clk) #1;
    check("pending", exp_q.size(), 0);
    $display("Test staging and commit done");
    final_report();
  end
endmodule
`default_nettype wire
